// file: bench/hpt_regs_monitor.sv
module hpt_regs_monitor
  import hpt_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic [ADDR_W-1:0]       reg_addr,
  input wire logic [DATA_W-1:0]       reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [DATA_W-1:0]       reg_rdata,
  input wire logic                    reg_rvalid,
  input wire hpt_link_s               up_link,
  input wire hpt_link_s               p1_link,
  input wire hpt_link_s               p2_link,
  input wire hpt_phy_tune_s           p1_tune,
  input wire hpt_phy_tune_s           p2_tune,
  input wire logic signed [PCT_W-1:0] p1_tx_pct,
  input wire logic signed [PCT_W-1:0] p2_tx_pct,
  input wire logic [TRIP_W-1:0]       p1_trip,
  input wire logic [TRIP_W-1:0]       p2_trip,
  input wire logic                    link_code_err
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_read_answer_once: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read answer timing wrong");
  chk_idle_rdata_zero: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  chk_up_status_read: assert property (reg_rd && reg_addr == OFS_UPSTREAM_SS_LINK_STATUS
    && !$past(rst) && $stable(up_link) && up_link.state <= 4'hB
    |=> reg_rdata == {$past(up_link.state), 1'b0, $past(up_link.sub)})
    else $error("upstream status read wrong");
  chk_p1_boost_write: assert property (reg_wr && reg_addr == OFS_PORT1_HS_TX_BOOST
    |=> {5'h00, p1_tune.tx_current_adjust} == ($past(reg_wdata) & 8'h07))
    else $error("port 1 boost code not taken");
  chk_p2_squelch_write: assert property (reg_wr && reg_addr == OFS_PORT2_RX_SQUELCH_TUNE
    |=> {5'h00, p2_tune.rx_squelch_trim} == ($past(reg_wdata) & 8'h07))
    else $error("port 2 squelch code not taken");
  chk_tune_hold: assert property (!reg_wr |=> $stable(p1_tune) && $stable(p2_tune))
    else $error("tuning changed without write");
  chk_boost_pct_map: assert property (p1_tx_pct == BOOST_PCT[p1_tune.tx_current_adjust])
    else $error("boost percent wrong");
  chk_squelch_trip_map: assert property (p2_trip == SQUELCH_TRIP[p2_tune.rx_squelch_trim])
    else $error("squelch trip wrong");
  chk_link_code_flag: assert property (!$past(rst) |-> link_code_err ==
    ($past(up_link.state) > 4'hB || $past(p1_link.state) > 4'hB
    || $past(p2_link.state) > 4'hB))
    else $error("link code flag wrong");
  cov_code_err: cover property (link_code_err);
  cov_p2_boost_read: cover property (reg_rd && reg_addr == OFS_PORT2_HS_TX_BOOST);
  cov_status_write: cover property (reg_wr && reg_addr == OFS_PORT1_SS_LINK_STATUS);
endmodule : hpt_regs_monitor

bind hpt_regs hpt_regs_monitor hpt_regs_monitor_inst (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .up_link(up_link), .p1_link(p1_link),
  .p2_link(p2_link), .p1_tune(p1_tune), .p2_tune(p2_tune), .p1_tx_pct(p1_tx_pct),
  .p2_tx_pct(p2_tx_pct), .p1_trip(p1_trip), .p2_trip(p2_trip), .link_code_err(link_code_err));

// file: bench/tb_hpt_regs.sv
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end

module tb_hpt_regs
  import hpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst, reg_wr, reg_rd, reg_rvalid, link_code_err;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  hpt_link_s up_link, p1_link, p2_link;
  hpt_phy_tune_s p1_tune, p2_tune;
  logic signed [5:0] p1_tx_pct, p2_tx_pct;
  logic [10:0] p1_trip, p2_trip;
  int error_cnt = 0, compares = 0, cyc = 0;
  logic signed [5:0] pct_exp [8] = '{6'sh00, -6'sh05, 6'sh0A, 6'sh05, 6'sh14, 6'sh0F, 6'sh1E,
    6'sh19};
  logic [10:0] trip_exp [8] = '{11'h3E8, 11'h36B, 11'h2EE, 11'h271, 11'h1F4, 11'h177, 11'h4E2,
    11'h465};
  logic [15:0] adr [8] = '{16'h61C0, 16'h64CA, 16'h64CC, 16'h65C0, 16'h68CA, 16'h68CC,
    16'h69C0, 16'h64CB};
  logic [7:0] rst_val [8] = '{8'h50, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'h50, 8'h00};

  hpt_regs hpt_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .up_link(up_link), .p1_link(p1_link), .p2_link(p2_link),
    .p1_tune(p1_tune), .p2_tune(p2_tune), .p1_tx_pct(p1_tx_pct), .p2_tx_pct(p2_tx_pct),
    .p1_trip(p1_trip), .p2_trip(p2_trip), .link_code_err(link_code_err));

  always #4 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(n, e, reg_rdata)
    `CHK("rvalid", 1'b1, reg_rvalid)
    @(posedge sys_clk);
  endtask : rd

  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    up_link = '{4'h5, 3'h0};
    p1_link = '{4'h5, 3'h0};
    p2_link = '{4'h5, 3'h0};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (adr[i]) rd(adr[i], rst_val[i], "reset value");
    `CHK("p1 trip", 11'h3E8, p1_trip)
    for (int c = 0; c < 8; c++) begin
      wr(OFS_PORT1_HS_TX_BOOST, {5'h1F, c[2:0]});
      wr(OFS_PORT2_RX_SQUELCH_TUNE, {5'h1F, c[2:0]});
      wr(OFS_PORT1_SS_LINK_STATUS, 8'hFF);
      wr(16'h64CB, 8'hFF);
      rd(OFS_PORT1_HS_TX_BOOST, {5'h00, c[2:0]}, "p1 boost");
      rd(OFS_PORT2_RX_SQUELCH_TUNE, {5'h00, c[2:0]}, "p2 squelch");
      `CHK("p1 tune", {c[2:0], 3'h0}, p1_tune)
      `CHK("p2 tune", {3'h0, c[2:0]}, p2_tune)
      `CHK("p1 pct", pct_exp[c], p1_tx_pct)
      `CHK("p2 trip", trip_exp[c], p2_trip)
    end
    rd(OFS_PORT1_SS_LINK_STATUS, 8'h50, "p1 status kept");
    wr(OFS_PORT2_HS_TX_BOOST, 8'h06);
    wr(OFS_PORT1_RX_SQUELCH_TUNE, 8'h05);
    `CHK("p2 pct", pct_exp[6], p2_tx_pct)
    `CHK("p1 trip", trip_exp[5], p1_trip)
    rd(OFS_PORT1_HS_TX_BOOST, 8'h07, "p1 boost kept");
    rd(OFS_PORT2_HS_TX_BOOST, 8'h06, "p2 boost");
    rd(OFS_PORT1_RX_SQUELCH_TUNE, 8'h05, "p1 squelch");
    `CHK("p1 tune both", 6'h3D, p1_tune)
    `CHK("p2 tune both", 6'h37, p2_tune)
    for (int s = 0; s < 12; s++) begin
      up_link <= '{s[3:0], s[2:0]};
      p1_link <= '{s[3:0], ~s[2:0]};
      p2_link <= '{4'hB - s[3:0], 3'h5};
      @(posedge sys_clk);
      wr(OFS_UPSTREAM_SS_LINK_STATUS, 8'h0F);
      rd(OFS_UPSTREAM_SS_LINK_STATUS, {s[3:0], 1'b0, s[2:0]}, "up status");
      rd(OFS_PORT1_SS_LINK_STATUS, {s[3:0], 1'b0, ~s[2:0]}, "p1 status");
      rd(OFS_PORT2_SS_LINK_STATUS, {4'hB - s[3:0], 4'h5}, "p2 status");
    end
    p1_link <= '{4'hC, 3'h1};
    @(posedge sys_clk);
    #1 `CHK("code err", 1'b1, link_code_err)
    rd(OFS_PORT1_SS_LINK_STATUS, 8'hB4, "p1 last valid");
    report_and_stop();
  end
endmodule : tb_hpt_regs

// file: pkg/hpt_pkg.sv
package hpt_pkg;

  // ---------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_UPSTREAM_SS_LINK_STATUS = 16'h61C0;
  localparam logic [15:0] OFS_PORT1_HS_TX_BOOST       = 16'h64CA;
  localparam logic [15:0] OFS_PORT1_RX_SQUELCH_TUNE   = 16'h64CC;
  localparam logic [15:0] OFS_PORT1_SS_LINK_STATUS    = 16'h65C0;
  localparam logic [15:0] OFS_PORT2_HS_TX_BOOST       = 16'h68CA;
  localparam logic [15:0] OFS_PORT2_RX_SQUELCH_TUNE   = 16'h68CC;
  localparam logic [15:0] OFS_PORT2_SS_LINK_STATUS    = 16'h69C0;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int LINK_STATE_LSB = 4;
  localparam int LINK_RSVD_BIT  = 3;
  localparam int LINK_SUB_LSB   = 0;
  localparam int CODE_LSB       = 0;
  localparam int CODE_W         = 3;
  localparam int CODE_RSVD_W    = 5;
  localparam int PCT_W          = 6;
  localparam int TRIP_W         = 11;

  // ---------------------------------------------------------------
  // Link states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    HPT_LS_U0         = 4'b0000,
    HPT_LS_U1         = 4'b0001,
    HPT_LS_U2         = 4'b0010,
    HPT_LS_U3         = 4'b0011,
    HPT_LS_DISABLED   = 4'b0100,
    HPT_LS_RX_DETECT  = 4'b0101,
    HPT_LS_INACTIVE   = 4'b0110,
    HPT_LS_POLLING    = 4'b0111,
    HPT_LS_RECOVERY   = 4'b1000,
    HPT_LS_HOT_RESET  = 4'b1001,
    HPT_LS_COMPLIANCE = 4'b1010,
    HPT_LS_LOOPBACK   = 4'b1011
  } hpt_link_state_e;

  typedef struct packed {
    logic [3:0] state;
    logic [2:0] sub;
  } hpt_link_s;

  typedef struct packed {
    logic [2:0] tx_current_adjust;
    logic [2:0] rx_squelch_trim;
  } hpt_phy_tune_s;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_LINK_STATE = 4'h5;
  localparam logic [2:0] RST_LINK_SUB   = 3'h0;
  localparam logic [2:0] RST_CODE       = 3'h0;
  localparam logic [7:0] RST_RDATA      = 8'h00;

  // ---------------------------------------------------------------
  // Code tables: percent change and trip point in 0.1 mV
  // ---------------------------------------------------------------
  localparam logic signed [5:0] BOOST_PCT [8] = '{
    6'sh00, -6'sh05, 6'sh0A, 6'sh05, 6'sh14, 6'sh0F, 6'sh1E, 6'sh19};
  localparam logic [10:0] SQUELCH_TRIP [8] = '{
    11'h3E8, 11'h36B, 11'h2EE, 11'h271, 11'h1F4, 11'h177, 11'h4E2, 11'h465};

endpackage : hpt_pkg

// file: rtl/hpt_regs.sv
module hpt_regs
  import hpt_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [DATA_W-1:0]        reg_rdata,
  output logic                          reg_rvalid,
  input  wire hpt_link_s                up_link,
  input  wire hpt_link_s                p1_link,
  input  wire hpt_link_s                p2_link,
  output hpt_phy_tune_s                 p1_tune,
  output hpt_phy_tune_s                 p2_tune,
  output logic signed [PCT_W-1:0]       p1_tx_pct,
  output logic signed [PCT_W-1:0]       p2_tx_pct,
  output logic      [TRIP_W-1:0]        p1_trip,
  output logic      [TRIP_W-1:0]        p2_trip,
  output logic                          link_code_err
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic code_ok(input logic [3:0] s);
    code_ok = (s <= HPT_LS_LOOPBACK);
  endfunction : code_ok

  function automatic logic [7:0] link_byte(input hpt_link_s l);
    logic [7:0] b;
    b = 8'h00;
    b[LINK_STATE_LSB +: 4] = l.state;
    b[LINK_RSVD_BIT]       = 1'b0;
    b[LINK_SUB_LSB +: 3]   = l.sub;
    link_byte = b;
  endfunction : link_byte

  function automatic logic [7:0] code_byte(input logic [2:0] c);
    code_byte = {{CODE_RSVD_W{1'b0}}, c};
  endfunction : code_byte

  function automatic hpt_link_s link_next(input hpt_link_s cur, input hpt_link_s in);
    link_next = code_ok(in.state) ? in : cur;
  endfunction : link_next

  function automatic logic signed [PCT_W-1:0] boost_pct(input logic [2:0] c);
    boost_pct = BOOST_PCT[c];
  endfunction : boost_pct

  function automatic logic [TRIP_W-1:0] squelch_trip(input logic [2:0] c);
    squelch_trip = SQUELCH_TRIP[c];
  endfunction : squelch_trip

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hpt_link_s          up_link_q;
  hpt_link_s          up_link_d;
  hpt_link_s          p1_link_q;
  hpt_link_s          p1_link_d;
  hpt_link_s          p2_link_q;
  hpt_link_s          p2_link_d;
  hpt_phy_tune_s      p1_tune_q;
  hpt_phy_tune_s      p1_tune_d;
  hpt_phy_tune_s      p2_tune_q;
  hpt_phy_tune_s      p2_tune_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic [DATA_W-1:0]  rd_mux;
  logic               rvalid_q;
  logic               err_q;
  logic               err_d;
  logic signed [PCT_W-1:0] p1_pct_q;
  logic signed [PCT_W-1:0] p2_pct_q;
  logic [TRIP_W-1:0]  p1_trip_q;
  logic [TRIP_W-1:0]  p2_trip_q;
  logic               rvalid_d;
  logic signed [PCT_W-1:0] p1_pct_d;
  logic signed [PCT_W-1:0] p2_pct_d;
  logic [TRIP_W-1:0]  p1_trip_d;
  logic [TRIP_W-1:0]  p2_trip_d;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam hpt_link_s     LINK_RST = '{state: RST_LINK_STATE, sub: RST_LINK_SUB};
  localparam hpt_phy_tune_s TUNE_RST = '{tx_current_adjust: RST_CODE, rx_squelch_trim: RST_CODE};

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire sel_up_stat  = (reg_addr == OFS_UPSTREAM_SS_LINK_STATUS);
  wire sel_p1_boost = (reg_addr == OFS_PORT1_HS_TX_BOOST);
  wire sel_p1_sq    = (reg_addr == OFS_PORT1_RX_SQUELCH_TUNE);
  wire sel_p1_stat  = (reg_addr == OFS_PORT1_SS_LINK_STATUS);
  wire sel_p2_boost = (reg_addr == OFS_PORT2_HS_TX_BOOST);
  wire sel_p2_sq    = (reg_addr == OFS_PORT2_RX_SQUELCH_TUNE);
  wire sel_p2_stat  = (reg_addr == OFS_PORT2_SS_LINK_STATUS);

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  wire wr_p1_boost = reg_wr && sel_p1_boost;
  wire wr_p1_sq    = reg_wr && sel_p1_sq;
  wire wr_p2_boost = reg_wr && sel_p2_boost;
  wire wr_p2_sq    = reg_wr && sel_p2_sq;

  // ---------------------------------------------------------------
  // Write data field
  // ---------------------------------------------------------------
  wire [2:0] wcode = reg_wdata[CODE_LSB +: CODE_W];

  // ---------------------------------------------------------------
  // Link state code checks
  // ---------------------------------------------------------------
  wire up_bad = !code_ok(up_link.state);
  wire p1_bad = !code_ok(p1_link.state);
  wire p2_bad = !code_ok(p2_link.state);

  // ---------------------------------------------------------------
  // Link status next values
  // ---------------------------------------------------------------
  always_comb begin
    up_link_d = link_next(up_link_q, up_link);
    p1_link_d = link_next(p1_link_q, p1_link);
    p2_link_d = link_next(p2_link_q, p2_link);
    err_d     = up_bad || p1_bad || p2_bad;
  end

  // ---------------------------------------------------------------
  // Tuning code writes
  // ---------------------------------------------------------------
  always_comb begin
    p1_tune_d = p1_tune_q;
    p2_tune_d = p2_tune_q;
    if (wr_p1_boost) begin
      p1_tune_d.tx_current_adjust = wcode;
    end
    if (wr_p1_sq) begin
      p1_tune_d.rx_squelch_trim = wcode;
    end
    if (wr_p2_boost) begin
      p2_tune_d.tx_current_adjust = wcode;
    end
    if (wr_p2_sq) begin
      p2_tune_d.rx_squelch_trim = wcode;
    end
  end

  // ---------------------------------------------------------------
  // Read views
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] up_stat_byte  = link_byte(up_link_q);
  wire [DATA_W-1:0] p1_boost_byte = code_byte(p1_tune_q.tx_current_adjust);
  wire [DATA_W-1:0] p1_sq_byte    = code_byte(p1_tune_q.rx_squelch_trim);
  wire [DATA_W-1:0] p1_stat_byte  = link_byte(p1_link_q);
  wire [DATA_W-1:0] p2_boost_byte = code_byte(p2_tune_q.tx_current_adjust);
  wire [DATA_W-1:0] p2_sq_byte    = code_byte(p2_tune_q.rx_squelch_trim);
  wire [DATA_W-1:0] p2_stat_byte  = link_byte(p2_link_q);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    if (sel_up_stat) begin
      rd_mux = up_stat_byte;
    end else if (sel_p1_boost) begin
      rd_mux = p1_boost_byte;
    end else if (sel_p1_sq) begin
      rd_mux = p1_sq_byte;
    end else if (sel_p1_stat) begin
      rd_mux = p1_stat_byte;
    end else if (sel_p2_boost) begin
      rd_mux = p2_boost_byte;
    end else if (sel_p2_sq) begin
      rd_mux = p2_sq_byte;
    end else if (sel_p2_stat) begin
      rd_mux = p2_stat_byte;
    end else begin
      rd_mux = RST_RDATA;
    end
  end

  assign rdata_d  = reg_rd ? rd_mux : RST_RDATA;
  assign rvalid_d = reg_rd;

  // ---------------------------------------------------------------
  // Upstream link status register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      up_link_q <= LINK_RST;
    end else begin
      up_link_q <= up_link_d;
    end
  end

  // ---------------------------------------------------------------
  // Port 1 link status register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p1_link_q <= LINK_RST;
    end else begin
      p1_link_q <= p1_link_d;
    end
  end

  // ---------------------------------------------------------------
  // Port 2 link status register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p2_link_q <= LINK_RST;
    end else begin
      p2_link_q <= p2_link_d;
    end
  end

  // ---------------------------------------------------------------
  // Link code error flag
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end

  // ---------------------------------------------------------------
  // Port 1 tuning register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p1_tune_q <= TUNE_RST;
    end else begin
      p1_tune_q <= p1_tune_d;
    end
  end

  // ---------------------------------------------------------------
  // Port 2 tuning register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p2_tune_q <= TUNE_RST;
    end else begin
      p2_tune_q <= p2_tune_d;
    end
  end

  // ---------------------------------------------------------------
  // Read port registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // Analog setting lookup
  // ---------------------------------------------------------------
  assign p1_pct_d  = boost_pct(p1_tune_d.tx_current_adjust);
  assign p2_pct_d  = boost_pct(p2_tune_d.tx_current_adjust);
  assign p1_trip_d = squelch_trip(p1_tune_d.rx_squelch_trim);
  assign p2_trip_d = squelch_trip(p2_tune_d.rx_squelch_trim);

  // ---------------------------------------------------------------
  // Port 1 analog settings
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p1_pct_q <= BOOST_PCT[RST_CODE];
    end else begin
      p1_pct_q <= p1_pct_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p1_trip_q <= SQUELCH_TRIP[RST_CODE];
    end else begin
      p1_trip_q <= p1_trip_d;
    end
  end

  // ---------------------------------------------------------------
  // Port 2 analog settings
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p2_pct_q <= BOOST_PCT[RST_CODE];
    end else begin
      p2_pct_q <= p2_pct_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p2_trip_q <= SQUELCH_TRIP[RST_CODE];
    end else begin
      p2_trip_q <= p2_trip_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata     = rdata_q;
  assign reg_rvalid    = rvalid_q;

  // ---------------------------------------------------------------
  // Port PHY outputs and link code error flag
  // ---------------------------------------------------------------
  assign p1_tune       = p1_tune_q;
  assign p2_tune       = p2_tune_q;
  assign p1_tx_pct     = p1_pct_q;
  assign p2_tx_pct     = p2_pct_q;
  assign p1_trip       = p1_trip_q;
  assign p2_trip       = p2_trip_q;
  assign link_code_err = err_q;

endmodule : hpt_regs
